// ==== rtl/sac_map.svh ====
// field positions, reset values and timing counts of the converter control
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH
`define SAC_RES_W 10
`define SAC_CHAN_W 3
`define SAC_NUM_CHAN 6
`define SAC_MODE_EN_BIT 7
`define SAC_MODE_FR_MSB 5
`define SAC_MODE_FR_LSB 3
`define SAC_MODE_RST 8'h00
`define SAC_CHAN_RST 3'h0
`define SAC_CT_CODE0 8'h90
`define SAC_CT_CODE1 8'h78
`define SAC_CT_CODE2 8'h60
`define SAC_CT_CODE4 8'h48
`define SAC_CT_CODE5 8'h3c
`define SAC_CT_CODE6 8'h30
`define SAC_SAMPLE_SLOTS 4'h2
`define SAC_TOTAL_SLOTS (`SAC_RES_W + 2)
`endif

// ==== rtl/sac_pkg.sv ====
// types and decode functions of the converter control
package sac_pkg;
`include "sac_map.svh"
	typedef logic [`SAC_RES_W-1:0] sac_res_t;
	typedef logic [`SAC_CHAN_W-1:0] sac_chan_t;
	typedef logic [2:0] sac_code_t;
	typedef logic [3:0] sac_idx_t;
	typedef enum logic [2:0] {
		SAC_ST_IDLE = 3'h1,
		SAC_ST_SAMPLE = 3'h2,
		SAC_ST_CONV = 3'h4
	} sac_state_t;

	// clock periods per conversion; unlisted codes fall back to the slowest time
	function automatic logic [7:0] sac_periods(input sac_code_t code);
		case (code)
			3'h0: return `SAC_CT_CODE0;
			3'h1: return `SAC_CT_CODE1;
			3'h2: return `SAC_CT_CODE2;
			3'h4: return `SAC_CT_CODE4;
			3'h5: return `SAC_CT_CODE5;
			3'h6: return `SAC_CT_CODE6;
			default: return `SAC_CT_CODE0;
		endcase
	endfunction : sac_periods

	function automatic logic [7:0] sac_step_len(input sac_code_t code);
		return sac_periods(code) / 8'(`SAC_TOTAL_SLOTS);
	endfunction : sac_step_len

	function automatic logic sac_code_bad(input sac_code_t code);
		return !(code inside {3'h0, 3'h1, 3'h2, 3'h4});
	endfunction : sac_code_bad
endpackage : sac_pkg

// ==== rtl/sac_if.sv ====
// links the sequencer to its step timer and approximation register
`timescale 1ns/10ps
interface sac_if;
	import sac_pkg::*;
	logic run;
	logic restart;
	sac_code_t code;
	logic tick;
	logic sar_start;
	logic abort;
	logic cmp;
	sac_res_t sar_val;
	sac_res_t sar_final;
	logic done;
	modport timer (input run, input restart, input code, output tick);
	modport sar (input sar_start, input abort, input tick, input cmp,
		output sar_val, output sar_final, output done);
endinterface : sac_if

// ==== rtl/sac_timer.sv ====
// step timer: one tick per conversion slot
`timescale 1ns/10ps
module sac_timer (
	input wire logic sys_clk,
	input wire logic resetn,
	sac_if.timer bus
);
	import sac_pkg::*;
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	logic [7:0] len;
	logic wrap;

	assign len = sac_step_len(bus.code);
	assign wrap = (cnt_r == len - 8'h01);
	// restart clears the count so the first slot is always full length
	assign bus.tick = bus.run && !bus.restart && wrap;

	always_comb begin
		if (!bus.run || bus.restart || wrap) begin
			cnt_nxt = 8'h00;
		end else begin
			cnt_nxt = cnt_r + 8'h01;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= 8'h00;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule : sac_timer

// ==== rtl/sac_sar.sv ====
// approximation register: one comparator decision per tick, msb first
`timescale 1ns/10ps
module sac_sar (
	input wire logic sys_clk,
	input wire logic resetn,
	sac_if.sar bus
);
	import sac_pkg::*;
	sac_res_t approximation_shift_reg_r;
	sac_res_t approximation_shift_reg_nxt;
	sac_idx_t idx_r;
	sac_idx_t idx_nxt;
	logic act_r;
	logic act_nxt;

	assign bus.sar_val = approximation_shift_reg_r;
	assign bus.done = act_r && bus.tick && (idx_r == 4'h0) && !bus.abort; // R14
	always_comb begin
		bus.sar_final = approximation_shift_reg_r;
		bus.sar_final[0] = bus.cmp;
	end

	always_comb begin
		approximation_shift_reg_nxt = approximation_shift_reg_r;
		idx_nxt = idx_r;
		act_nxt = act_r;
		if (bus.abort) begin
			act_nxt = 1'b0;
		end else if (bus.sar_start) begin
			approximation_shift_reg_nxt = '0; // R14
			approximation_shift_reg_nxt[`SAC_RES_W-1] = 1'b1; // R14
			idx_nxt = 4'(`SAC_RES_W - 1); // R1
			act_nxt = 1'b1;
		end else if (act_r && bus.tick) begin
			approximation_shift_reg_nxt[idx_r] = bus.cmp; // R14
			if (idx_r == 4'h0) begin
				act_nxt = 1'b0;
			end else begin
				approximation_shift_reg_nxt[idx_r - 4'h1] = 1'b1; // R14
				idx_nxt = idx_r - 4'h1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			approximation_shift_reg_r <= '0;
			idx_r <= 4'h0;
			act_r <= 1'b0;
		end else begin
			approximation_shift_reg_r <= approximation_shift_reg_nxt;
			idx_r <= idx_nxt;
			act_r <= act_nxt;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	property p_msb_first;
		bus.sar_start && !bus.abort |=> approximation_shift_reg_r[`SAC_RES_W-1]
			&& (approximation_shift_reg_r[`SAC_RES_W-2:0] == '0);
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("msb not trial-set at start"); // R14

	property p_step_down;
		act_r && bus.tick && !bus.abort && !bus.sar_start && (idx_r != 4'h0)
			|=> (idx_r == $past(idx_r) - 4'h1) && approximation_shift_reg_r[idx_r];
	endproperty
	a_step_down: assert property (p_step_down) else $error("bit walk out of order"); // R14
endmodule : sac_sar

// ==== rtl/sac_top.sv ====
// converter control: mode, channel and result registers with the conversion sequencer
// How it works
// R1: result width is eight or ten bits; the code gives ten bits only
// R2: standby or cleared enable halts conversion
// R3: coinciding read gets old result, store follows
// R4: coinciding mode or channel write wins
// R5: software discards first result after start
// R6: software reads results while conversion runs
// R7: mode write never clears the done flag
// R8: flag may reflect the previous channel
// R9: software clears done flag before restarting
// R10: avoid digital reads on selected shared pin
// R11: ten-bit result, one of six inputs
// R12: only a register write starts conversion; the code also starts one when standby falls with the enable bit set
// R13: back-to-back conversions, interrupt after each
// R14: decisions msb first, then transfer result
// R15: result loaded from approximation register each end
// R16: result read as one 16-bit word
// R17: result register has no reset value
// R18: input held whole conversion, resampled next
// R19: enable bit set starts selected channel
// R20: mode or channel write cancels and restarts
// R21: time field picks 144/120/96/72 clocks
// R22: channel codes 0 to 5 only
`timescale 1ns/10ps
`include "sac_map.svh"
module sac_top (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic standby,
	input wire logic mode_wr,
	input wire logic [7:0] mode_wdata,
	input wire logic chan_wr,
	input wire logic [7:0] chan_wdata,
	input wire logic result_rd,
	input wire logic flag_clr,
	input wire logic comparator_in,
	output logic [7:0] mode_rdata,
	output logic [7:0] chan_rdata,
	output logic [15:0] result_rdata,
	output logic conversion_done_flag,
	output logic conversion_done_irq,
	output logic sample_hold,
	output logic [`SAC_NUM_CHAN-1:0] analog_input_pins_sel,
	output sac_pkg::sac_res_t tap_code,
	output logic conv_busy,
	output logic time_code_prohibited,
	output logic chan_code_prohibited
);
	import sac_pkg::*;

	sac_if u_if ();

	sac_timer u_timer (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.bus(u_if)
	);

	sac_sar u_sar (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.bus(u_if)
	);

	// configuration
	logic conv_enable_bit_r;
	logic conv_enable_bit_nxt;
	sac_code_t conv_time_select_r;
	sac_code_t conv_time_select_nxt;
	sac_chan_t channel_select_reg_r;
	sac_chan_t channel_select_reg_nxt;

	// sequencer
	sac_state_t state_r;
	sac_state_t state_nxt;
	logic [3:0] slot_r;
	logic [3:0] slot_nxt;
	logic restart;
	logic sar_start;
	logic go;
	logic wr_any;

	// result and flag
	sac_res_t conversion_result_reg_r;
	sac_res_t conversion_result_reg_nxt;
	sac_res_t pend_val_r;
	sac_res_t pend_val_nxt;
	logic pend_r;
	logic pend_nxt;
	logic flag_r;
	logic flag_nxt;
	logic irq_r;
	logic irq_nxt;
	logic load;
	// the result holds real data only once a conversion has been stored since reset
	logic stored_r;
	logic stored_nxt;

	// analog side
	logic sample_r;
	logic sample_nxt;
	logic [`SAC_NUM_CHAN-1:0] sel_r;
	logic [`SAC_NUM_CHAN-1:0] sel_nxt;

	assign wr_any = mode_wr || chan_wr;

	always_comb begin
		conv_enable_bit_nxt = conv_enable_bit_r;
		conv_time_select_nxt = conv_time_select_r;
		channel_select_reg_nxt = channel_select_reg_r;
		if (mode_wr) begin
			conv_enable_bit_nxt = mode_wdata[`SAC_MODE_EN_BIT];
			conv_time_select_nxt = mode_wdata[`SAC_MODE_FR_MSB:`SAC_MODE_FR_LSB]; // R21
		end
		if (chan_wr) begin
			channel_select_reg_nxt = chan_wdata[`SAC_CHAN_W-1:0]; // R22
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			conv_enable_bit_r <= 1'b0;
			conv_time_select_r <= 3'(`SAC_MODE_RST >> `SAC_MODE_FR_LSB);
			channel_select_reg_r <= `SAC_CHAN_RST;
		end else begin
			conv_enable_bit_r <= conv_enable_bit_nxt;
			conv_time_select_r <= conv_time_select_nxt;
			channel_select_reg_r <= channel_select_reg_nxt;
		end
	end

	// the sequencer leaves idle only while the enable bit is set and standby is low: no other trigger exists
	always_comb begin
		state_nxt = state_r;
		slot_nxt = slot_r;
		restart = 1'b0;
		sar_start = 1'b0;
		go = conv_enable_bit_nxt && !standby; // R2
		if (!go) begin
			state_nxt = SAC_ST_IDLE; // R2
		end else if (wr_any || state_r == SAC_ST_IDLE) begin
			state_nxt = SAC_ST_SAMPLE; // R12 R19 R20
			slot_nxt = 4'h0;
			restart = 1'b1; // R20
		end else begin
			case (state_r)
				SAC_ST_SAMPLE: begin
					if (u_if.tick) begin
						if (slot_r == `SAC_SAMPLE_SLOTS - 4'h1) begin
							state_nxt = SAC_ST_CONV; // R18
							sar_start = 1'b1;
							slot_nxt = 4'h0;
						end else begin
							slot_nxt = slot_r + 4'h1;
						end
					end
				end
				SAC_ST_CONV: begin
					if (u_if.done) begin
						state_nxt = SAC_ST_SAMPLE; // R13
						slot_nxt = 4'h0;
					end
				end
				default: begin
					state_nxt = SAC_ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= SAC_ST_IDLE;
			slot_r <= 4'h0;
		end else begin
			state_r <= state_nxt;
			slot_r <= slot_nxt;
		end
	end

	assign u_if.run = (state_r != SAC_ST_IDLE);
	assign u_if.restart = restart;
	assign u_if.code = conv_time_select_r;
	assign u_if.sar_start = sar_start;
	// a write in the finishing cycle aborts the approximation, so done never fires then
	assign u_if.abort = restart || !go; // R4
	assign u_if.cmp = comparator_in;
	assign load = u_if.done; // R4

	always_comb begin
		conversion_result_reg_nxt = conversion_result_reg_r;
		pend_val_nxt = pend_val_r;
		pend_nxt = 1'b0;
		if (pend_r) begin
			conversion_result_reg_nxt = pend_val_r; // R3
		end
		if (load) begin
			if (result_rd) begin
				pend_nxt = 1'b1; // R3
				pend_val_nxt = u_if.sar_final;
			end else begin
				conversion_result_reg_nxt = u_if.sar_final; // R15
			end
		end
		// set wins over a clear in the same cycle; mode writes leave it alone
		if (load) begin
			flag_nxt = 1'b1; // R7
		end else if (flag_clr) begin
			flag_nxt = 1'b0;
		end else begin
			flag_nxt = flag_r; // R7 R8
		end
		irq_nxt = load; // R13
		stored_nxt = stored_r || load;
	end

	// no reset here: contents are undefined until the first conversion lands
	always_ff @(posedge sys_clk) begin
		conversion_result_reg_r <= conversion_result_reg_nxt; // R17
		pend_val_r <= pend_val_nxt;
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pend_r <= 1'b0;
			flag_r <= 1'b0;
			irq_r <= 1'b0;
			stored_r <= 1'b0;
		end else begin
			pend_r <= pend_nxt;
			flag_r <= flag_nxt;
			irq_r <= irq_nxt;
			stored_r <= stored_nxt;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < `SAC_NUM_CHAN; gi++) begin : g_sel
			assign sel_nxt[gi] = (state_nxt != SAC_ST_IDLE)
				&& (channel_select_reg_nxt == `SAC_CHAN_W'(gi)); // R11
		end
	endgenerate

	assign sample_nxt = (state_nxt == SAC_ST_SAMPLE); // R18

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sample_r <= 1'b0;
			sel_r <= '0;
		end else begin
			sample_r <= sample_nxt;
			sel_r <= sel_nxt;
		end
	end

	assign mode_rdata = {conv_enable_bit_r, 1'b0, conv_time_select_r, 3'h0};
	assign chan_rdata = {{(8-`SAC_CHAN_W){1'b0}}, channel_select_reg_r};
	assign result_rdata = {{(16-`SAC_RES_W){1'b0}}, conversion_result_reg_r}; // R16
	assign conversion_done_flag = flag_r;
	assign conversion_done_irq = irq_r;
	assign sample_hold = sample_r;
	assign analog_input_pins_sel = sel_r;
	assign tap_code = u_if.sar_val;
	assign conv_busy = (state_r != SAC_ST_IDLE);
	assign time_code_prohibited = sac_code_bad(conv_time_select_r); // R21
	assign chan_code_prohibited = (channel_select_reg_r >= `SAC_CHAN_W'(`SAC_NUM_CHAN)); // R22

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	property p_standby_stop;
		standby |=> !conv_busy && !sample_hold && (analog_input_pins_sel == '0);
	endproperty
	a_standby_stop: assert property (p_standby_stop) else $error("standby did not halt"); // R2

	property p_disable_stop;
		mode_wr && !mode_wdata[`SAC_MODE_EN_BIT] |=> !conv_busy ##1 !conversion_done_irq;
	endproperty
	a_disable_stop: assert property (p_disable_stop) else $error("clearing enable kept running"); // R2

	property p_read_old;
		load && result_rd |=> (conversion_result_reg_r == $past(conversion_result_reg_r))
			##1 (conversion_result_reg_r == $past(u_if.sar_final, 2));
	endproperty
	a_read_old: assert property (p_read_old) else $error("read conflict order wrong"); // R3

	property p_write_wins;
		wr_any && !pend_r && stored_r |=> !conversion_done_irq
			&& (conversion_result_reg_r == $past(conversion_result_reg_r));
	endproperty
	a_write_wins: assert property (p_write_wins) else $error("completion beat a write"); // R4

	property p_flag_kept;
		mode_wr && !flag_clr && conversion_done_flag |=> conversion_done_flag;
	endproperty
	a_flag_kept: assert property (p_flag_kept) else $error("mode write cleared flag"); // R7

	property p_set_wins;
		load && flag_clr |=> conversion_done_flag && conversion_done_irq;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("clear beat a completion"); // R7

	property p_start;
		mode_wr && mode_wdata[`SAC_MODE_EN_BIT] && !standby |=> sample_hold
			&& (analog_input_pins_sel == ($past(chan_wr) ?
			(6'h01 << $past(chan_wdata[2:0])) : (6'h01 << channel_select_reg_r)));
	endproperty
	a_start: assert property (p_start) else $error("enable did not start sampling"); // R19

	property p_first_done;
		$rose(sample_hold) && !$past(conv_busy) |-> !conversion_done_irq [*8];
	endproperty
	a_first_done: assert property (p_first_done) else $error("result came too early"); // R13

	property p_repeat;
		conversion_done_irq && conv_busy |-> sample_hold && $past(state_r == SAC_ST_CONV);
	endproperty
	a_repeat: assert property (p_repeat) else $error("no back to back sampling"); // R13

	property p_hold;
		state_r == SAC_ST_CONV |-> !sample_hold && (tap_code != '0 || u_if.sar_final[0]);
	endproperty
	a_hold: assert property (p_hold) else $error("sampled during conversion"); // R18

	property p_one_input;
		1'b1 |-> $onehot0(analog_input_pins_sel);
	endproperty
	a_one_input: assert property (p_one_input) else $error("two inputs selected"); // R11

	c_done: cover property (load ##[1:200] load);
	c_read_conflict: cover property (load && result_rd);
	c_write_conflict: cover property (state_r == SAC_ST_CONV && u_if.tick && wr_any);
	c_standby: cover property (conv_busy ##1 standby);
endmodule : sac_top

// ==== tb/sac_cmp_model.sv ====
// comparator and sample-and-hold model facing the converter control
`timescale 1ns/10ps
module sac_cmp_model (
	input wire logic sys_clk,
	input wire logic sample_hold,
	input wire logic [5:0] sel,
	input wire sac_pkg::sac_res_t tap_code,
	input wire sac_pkg::sac_res_t level [6],
	output logic comparator_in
);
	import sac_pkg::*;
	sac_res_t held_r;
	sac_res_t pick;
	always_comb begin
		// nothing selected: the node floats, so hand back a changing value
		pick = ~held_r;
		for (int i = 0; i < 6; i++) begin
			if (sel[i])
				pick = level[i];
		end
	end
	always_ff @(posedge sys_clk) begin
		if (sample_hold)
			held_r <= pick;
	end
	assign comparator_in = (held_r >= tap_code);
endmodule : sac_cmp_model

// ==== tb/tb.sv ====
// self-checking bench of the converter control
`timescale 1ns/10ps
module tb;
	import sac_pkg::*;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic standby = 1'b0;
	logic mode_wr = 1'b0;
	logic chan_wr = 1'b0;
	logic result_rd = 1'b0;
	logic flag_clr = 1'b0;
	logic [7:0] mode_wdata = 8'h00;
	logic [7:0] chan_wdata = 8'h00;
	logic comparator_in, done_flag, done_irq, sample_hold, conv_busy, t_bad, c_bad;
	logic [7:0] mode_rdata, chan_rdata;
	logic [15:0] result_rdata;
	logic [5:0] sel;
	sac_res_t tap_code;
	sac_res_t lvl [6] = '{default: 10'h000};
	int failures = 0;
	int checks_done = 0;
	int n;
	always #5 sys_clk = ~sys_clk;
	sac_top u_sac_top (.sys_clk(sys_clk), .resetn(resetn), .standby(standby),
		.mode_wr(mode_wr), .mode_wdata(mode_wdata), .chan_wr(chan_wr),
		.chan_wdata(chan_wdata), .result_rd(result_rd), .flag_clr(flag_clr),
		.comparator_in(comparator_in), .mode_rdata(mode_rdata), .chan_rdata(chan_rdata),
		.result_rdata(result_rdata), .conversion_done_flag(done_flag),
		.conversion_done_irq(done_irq), .sample_hold(sample_hold),
		.analog_input_pins_sel(sel), .tap_code(tap_code), .conv_busy(conv_busy),
		.time_code_prohibited(t_bad), .chan_code_prohibited(c_bad));
	sac_cmp_model u_sac_cmp_model (.sys_clk(sys_clk), .sample_hold(sample_hold),
		.sel(sel), .tap_code(tap_code), .level(lvl), .comparator_in(comparator_in));
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t value %h expected %h", $time, got, exp);
		end
	endtask : chk_val
	task automatic chk_bit(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t bit %b expected %b", $time, got, exp);
		end
	endtask : chk_bit
	task automatic chk_cnt(input int got, input int exp);
		checks_done++;
		if (got != exp) begin
			failures++;
			$display("[ERR] %0t count %0d expected %0d", $time, got, exp);
		end
	endtask : chk_cnt
	task automatic print_verdict;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : print_verdict
	task automatic wr_mode(input logic [7:0] d);
		@(negedge sys_clk);
		mode_wr = 1'b1;
		mode_wdata = d;
		@(negedge sys_clk);
		mode_wr = 1'b0;
	endtask : wr_mode
	task automatic wr_chan(input logic [7:0] d);
		@(negedge sys_clk);
		chan_wr = 1'b1;
		chan_wdata = d;
		@(negedge sys_clk);
		chan_wr = 1'b0;
	endtask : wr_chan
	task automatic pulse_rd;
		@(negedge sys_clk);
		result_rd = 1'b1;
		@(negedge sys_clk);
		result_rd = 1'b0;
	endtask : pulse_rd
	task automatic pulse_clr;
		@(negedge sys_clk);
		flag_clr = 1'b1;
		@(negedge sys_clk);
		flag_clr = 1'b0;
	endtask : pulse_clr
	// counts falling edges until the completion pulse shows, bounded
	task automatic wait_irq(output int cnt);
		cnt = 0;
		do begin
			@(negedge sys_clk);
			cnt++;
		end while (done_irq !== 1'b1 && cnt < 2000);
	endtask : wait_irq
	task automatic quiet(input int cyc);
		int hits;
		hits = 0;
		repeat (cyc) begin
			@(negedge sys_clk);
			hits += int'(done_irq !== 1'b0) + int'(conv_busy !== 1'b0);
		end
		chk_cnt(hits, 0);
	endtask : quiet
	task automatic start(input logic [2:0] cd, input logic [2:0] ch);
		pulse_clr();
		wr_chan({5'h00, ch});
		wr_mode({2'b10, cd, 3'b000});
		chk_bit(conv_busy, 1'b1);
		chk_val(16'(sel), 16'(6'h01 << ch));
		chk_bit(sample_hold, 1'b1);
	endtask : start
	task automatic t_codes;
		for (int c = 0; c < 8; c++) begin
			wr_mode({2'b00, 3'(c), 3'b000});
			wr_chan({5'h00, 3'(c)});
			chk_val(16'(mode_rdata), {10'h000, 3'(c), 3'b000});
			chk_val(16'(chan_rdata), {13'h0000, 3'(c)});
			chk_bit(t_bad, c == 3 || c >= 5);
			chk_bit(c_bad, c >= 6);
		end
	endtask : t_codes
	task automatic t_timing;
		int per [4] = '{144, 120, 96, 72};
		logic [2:0] cd [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
		sac_res_t v;
		for (int i = 0; i < 4; i++) begin
			lvl[i] = 10'h2a5 + 10'(i * 77);
			v = lvl[i];
			start(cd[i], 3'(i));
			wait_irq(n);
			chk_cnt(n, per[i]);
			chk_val(result_rdata, {6'h00, v});
			chk_bit(done_flag, 1'b1);
			// flip the input once the sample slots are over
			repeat (per[i] / 6 + 2) @(negedge sys_clk);
			chk_bit(sample_hold, 1'b0);
			chk_val(16'(tap_code), 16'h0200);
			lvl[i] = ~v;
			wait_irq(n);
			chk_cnt(n, per[i] - per[i] / 6 - 2);
			chk_val(result_rdata, {6'h00, v});
			wr_mode(8'h00);
			chk_bit(conv_busy, 1'b0);
		end
	endtask : t_timing
	task automatic t_conflict;
		lvl[5] = 10'h155;
		start(3'h4, 3'h5);
		wait_irq(n);
		lvl[5] = 10'h3c3;
		repeat (70) @(negedge sys_clk);
		pulse_rd();
		chk_val(result_rdata, 16'h0155);
		@(negedge sys_clk);
		chk_val(result_rdata, 16'h03c3);
		lvl[5] = 10'h0f0;
		repeat (69) @(negedge sys_clk);
		wr_mode(8'ha0);
		chk_bit(done_irq, 1'b0);
		chk_val(result_rdata, 16'h03c3);
		chk_bit(done_flag, 1'b1);
		wait_irq(n);
		chk_cnt(n, 72);
		chk_val(result_rdata, 16'h00f0);
		repeat (70) @(negedge sys_clk);
		wr_chan(8'h05);
		chk_bit(done_irq, 1'b0);
		chk_val(result_rdata, 16'h00f0);
		wait_irq(n);
		chk_cnt(n, 72);
		// clear strobe lands on the next completion edge: the set must win
		repeat (70) @(negedge sys_clk);
		pulse_clr();
		chk_bit(done_flag, 1'b1);
		chk_bit(done_irq, 1'b1);
		pulse_clr();
		chk_bit(done_flag, 1'b0);
		wr_mode(8'h00);
	endtask : t_conflict
	task automatic t_stop;
		start(3'h4, 3'h4);
		wait_irq(n);
		standby = 1'b1;
		quiet(150);
		standby = 1'b0;
		wait_irq(n);
		chk_bit(done_irq, 1'b1);
		wr_mode(8'h20);
		quiet(160);
	endtask : t_stop
	initial begin
		repeat (4) @(negedge sys_clk);
		resetn = 1'b1;
		chk_val(16'(mode_rdata), 16'h0000);
		chk_val(16'(chan_rdata), 16'h0000);
		chk_bit(done_flag, 1'b0);
		quiet(20);
		t_codes();
		t_timing();
		t_conflict();
		t_stop();
		print_verdict();
	end
	// the full run needs about 1900 cycles; this leaves ample margin
	initial begin
		repeat (20000) @(posedge sys_clk);
		failures++;
		print_verdict();
	end
endmodule : tb
